// file: dtsl_steering_latch.sv
`timescale 1ns/1ns
`default_nettype none
module dtsl_steering_latch #(
    parameter int GUARD_PRESENT_CYC_P = dtsl_pkg::GUARD_PRESENT_CYC,
    parameter int GUARD_ABSENT_CYC_P = dtsl_pkg::GUARD_ABSENT_CYC,
    parameter int RECOVERY_CYC_P = dtsl_pkg::RECOVERY_CYC
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic tone_valid_in,
    input wire logic [dtsl_pkg::CODE_W-1:0] tone_code_in,
    input wire logic power_down_in,
    input wire logic code_output_enable_in,
    input wire logic host_ready_in,
    output logic early_detect_out,
    output logic guard_steer_pin_out,
    output logic delayed_valid_strobe_out,
    output logic [dtsl_pkg::CODE_W-1:0] tone_code_out,
    output logic [dtsl_pkg::CODE_W-1:0] tone_code_oe_out,
    output logic code_valid_out,
    output logic [dtsl_pkg::CODE_W-1:0] code_data_out
);
    import dtsl_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_HELD} dtsl_state_t;

    dtsl_state_t state;
    logic [CNT_W-1:0] rec_cnt;
    logic recovered;
    logic [CNT_W-1:0] guard_cnt;
    logic steer;
    logic [SETUP_W-1:0] setup_cnt;
    logic present;
    logic [CODE_W-1:0] code_q;
    // two-entry buffer toward the host
    logic [CODE_W-1:0] buf_mem [2];
    logic buf_wp;
    logic buf_rp;
    logic [1:0] buf_cnt;
    logic buf_push;
    logic buf_pop;
    logic buf_ready;

    function automatic logic cnt_done(input logic [CNT_W-1:0] c, input int lim);
        cnt_done = (c >= CNT_W'(lim - 1));
    endfunction

    // power-down stops detection; recovery time counted after release
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rec_cnt <= '0;
            recovered <= 1'b0;
        end else if (power_down_in) begin
            rec_cnt <= '0;
            recovered <= 1'b0;
        end else if (!recovered) begin
            if (cnt_done(rec_cnt, RECOVERY_CYC_P)) begin
                recovered <= 1'b1;
            end else begin
                rec_cnt <= rec_cnt + 1'b1;
            end
        end
    end

    assign present = tone_valid_in && recovered;

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            early_detect_out <= 1'b0;
        end else begin
            early_detect_out <= present;
        end
    end

    // guard counter: runs while input disagrees with steering state
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            guard_cnt <= '0;
            steer <= 1'b0;
        end else if (present == steer) begin
            guard_cnt <= '0;
        end else if (!steer && cnt_done(guard_cnt, GUARD_PRESENT_CYC_P)) begin
            steer <= 1'b1;
            guard_cnt <= '0;
        end else if (steer && cnt_done(guard_cnt, GUARD_ABSENT_CYC_P)) begin
            steer <= 1'b0;
            guard_cnt <= '0;
        end else begin
            guard_cnt <= guard_cnt + 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            guard_steer_pin_out <= 1'b0;
        end else begin
            guard_steer_pin_out <= steer;
        end
    end

    // latch at steering rise, then hold code SETUP_CYC before the strobe
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= ST_IDLE;
            code_q <= CODE_RST;
            setup_cnt <= '0;
            delayed_valid_strobe_out <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (steer && !guard_steer_pin_out) begin
                        code_q <= tone_code_in;
                        setup_cnt <= '0;
                        state <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (setup_cnt >= SETUP_W'(SETUP_CYC - 1)) begin
                        delayed_valid_strobe_out <= 1'b1;
                        state <= ST_HELD;
                    end else begin
                        setup_cnt <= setup_cnt + 1'b1;
                    end
                end
                ST_HELD: begin
                    if (!steer) begin
                        delayed_valid_strobe_out <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign tone_code_out = code_q;
    assign tone_code_oe_out = {CODE_W{code_output_enable_in}};

    // each strobe rise offers one word; a full buffer drops it, code pins still hold it
    assign buf_ready = (buf_cnt != 2'd2);
    assign buf_push = (state == ST_SETUP) && (setup_cnt >= SETUP_W'(SETUP_CYC - 1)) && buf_ready;
    assign buf_pop = code_valid_out && host_ready_in;
    assign code_valid_out = (buf_cnt != 2'd0);
    assign code_data_out = buf_mem[buf_rp];

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            buf_mem[0] <= CODE_RST;
            buf_mem[1] <= CODE_RST;
            buf_wp <= 1'b0;
            buf_rp <= 1'b0;
            buf_cnt <= 2'd0;
        end else begin
            if (buf_push) begin
                buf_mem[buf_wp] <= code_q;
                buf_wp <= ~buf_wp;
            end
            if (buf_pop) begin
                buf_rp <= ~buf_rp;
            end
            buf_cnt <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
        end
    end

    // strobe rises SETUP_CYC cycles after the guard pin rises; the bound allows setup count plus one
    localparam int STROBE_LEAD_MAX = SETUP_CYC + 1;

    // run lengths of presence and absence, read only by the guard checks
    logic [CNT_W-1:0] pres_run;
    logic [CNT_W-1:0] abs_run;

    function automatic logic [CNT_W-1:0] run_step(input logic [CNT_W-1:0] c);
        run_step = (c == '1) ? c : c + 1'b1;
    endfunction

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pres_run <= '0;
            abs_run <= '0;
        end else begin
            pres_run <= present ? run_step(pres_run) : '0;
            abs_run <= present ? '0 : run_step(abs_run);
        end
    end

    a_code_before_strobe: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        $rose(delayed_valid_strobe_out) |-> $stable(tone_code_out))
        else $error("code changed as strobe rose");

    a_short_burst_hold: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (state == ST_IDLE && !(steer && !guard_steer_pin_out)) |=> $stable(tone_code_out))
        else $error("code changed without qualified tone");

    a_strobe_lead: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        $rose(guard_steer_pin_out) |-> ##[1:STROBE_LEAD_MAX] delayed_valid_strobe_out)
        else $error("strobe late after steering");

    a_code_latched: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (steer && !guard_steer_pin_out && state == ST_IDLE) |=> tone_code_out == $past(tone_code_in))
        else $error("code not latched");

    a_oe_follows: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        tone_code_oe_out == {CODE_W{code_output_enable_in}})
        else $error("output enable wrong");

    a_early_detect: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        ##1 early_detect_out == $past(tone_valid_in && recovered))
        else $error("early detect wrong");

    a_strobe_drop: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        $fell(steer) |=> !delayed_valid_strobe_out)
        else $error("strobe stayed after absence");

    a_dropout_hold: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (steer && !present && guard_cnt < CNT_W'(GUARD_ABSENT_CYC_P - 1)) |=> steer)
        else $error("short dropout ended tone");

    a_pd_silent: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        power_down_in |=> ##1 !early_detect_out)
        else $error("early detect during power-down");

    a_steer_rise_guard: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        $rose(steer) |-> pres_run >= CNT_W'(GUARD_PRESENT_CYC_P))
        else $error("steering rose before presence guard time");

    a_steer_fall_guard: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        $fell(steer) |-> abs_run >= CNT_W'(GUARD_ABSENT_CYC_P))
        else $error("steering fell before absence guard time");

    a_strobe_needs_pin: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        delayed_valid_strobe_out |-> guard_steer_pin_out)
        else $error("strobe high without guard steering");

    a_code_busy_hold: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (state != ST_IDLE) |=> $stable(tone_code_out))
        else $error("code changed while a tone is held");

    a_latch_when_off: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (steer && !guard_steer_pin_out && state == ST_IDLE && !code_output_enable_in)
        |=> tone_code_out == $past(tone_code_in))
        else $error("code not latched while pins released");

    a_early_on_valid: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        present |=> early_detect_out)
        else $error("early detect missing with valid tone");

    a_early_off_idle: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        !present |=> !early_detect_out)
        else $error("early detect without valid tone");

    a_recover_quiet: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        !recovered |=> !early_detect_out)
        else $error("early detect before recovery");

    a_recover_count: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        $rose(recovered) |-> rec_cnt == CNT_W'(RECOVERY_CYC_P - 1))
        else $error("recovery time wrong");

    a_pin_follows: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        ##1 guard_steer_pin_out == $past(steer))
        else $error("guard steering pin wrong");

    a_strobe_rise_pin: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        $rose(delayed_valid_strobe_out) |-> guard_steer_pin_out)
        else $error("strobe rose without guard steering");

    a_idle_no_strobe: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (state == ST_IDLE) |-> !delayed_valid_strobe_out)
        else $error("strobe high with no tone held");

    a_oe_off_release: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        !code_output_enable_in |-> tone_code_oe_out == '0)
        else $error("code pins driven while disabled");

    a_push_with_strobe: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        buf_push |=> $rose(delayed_valid_strobe_out))
        else $error("word pushed without strobe rise");

    a_buf_bound: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        buf_cnt <= 2'h2)
        else $error("buffer count overflow");

    a_buf_stall_hold: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (code_valid_out && !host_ready_in) |=> code_valid_out && $stable(code_data_out))
        else $error("stalled word lost");

    a_latch_width: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        $rose(guard_steer_pin_out) |-> tone_code_out == $past(tone_code_in))
        else $error("latched code differs from decoded tone");
endmodule
`default_nettype wire

// file: dtsl_pkg.sv
package dtsl_pkg;
    localparam int CLK_HZ = 50000000;
    localparam int CODE_W = 4;
    localparam logic [3:0] CODE_RST = 4'h0;
    // guard times, default to the recommended 40 ms accept bound
    localparam int GUARD_PRESENT_TIME_MS = 40;
    localparam int GUARD_ABSENT_TIME_MS = 40;
    localparam int GUARD_PRESENT_CYC = GUARD_PRESENT_TIME_MS * (CLK_HZ / 1000);
    localparam int GUARD_ABSENT_CYC = GUARD_ABSENT_TIME_MS * (CLK_HZ / 1000);
    // power-down recovery
    localparam int TONE_RECOVERY_TIME_MS = 30;
    localparam int RECOVERY_CYC = TONE_RECOVERY_TIME_MS * (CLK_HZ / 1000);
    // code to strobe lead, 3.4 us typical, kept as a least time
    localparam int SETUP_TIME_NS = 3400;
    localparam int SETUP_CYC = (SETUP_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int CNT_W = 32;
    localparam int SETUP_W = 8;
endpackage

// file: dtsl_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module dtsl_host_model (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic valid_in,
    input wire logic [3:0] data_in,
    input wire logic stall_in,
    output logic ready_out,
    output int count_out,
    output logic [3:0] last_out
);
    // a stalling host forces the buffer to absorb words
    assign ready_out = !stall_in;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count_out <= 0;
            last_out <= 4'h0;
        end else if (valid_in && ready_out) begin
            count_out <= count_out + 1;
            last_out <= data_in;
        end
    end
endmodule
`default_nettype wire

// file: tb_dtsl_steering_latch.sv
`timescale 1ns/1ns
`default_nettype none
module tb_dtsl_steering_latch;
    import dtsl_pkg::*;
    localparam int G = 20;
    localparam int A = 20;
    localparam int R = 10;
    typedef struct {logic [3:0] c; int len; logic oe; logic st; logic [3:0] q;} dtsl_row_t;
    // short, long, long with pins released, one short of the guard
    dtsl_row_t rows [4] = '{'{4'h5, G-5, 1, 0, 4'h0}, '{4'h5, G+200, 1, 1, 4'h5},
                            '{4'hA, G+200, 0, 1, 4'hA}, '{4'h3, G-1, 1, 0, 4'hA}};
    logic clk = 0, rstn = 0, tv = 0, pd = 0, oe = 1, stall = 0, saw = 0;
    logic [3:0] code = 4'h0;
    logic ed, gp, sd, cv, hr;
    logic [3:0] q, qoe, cd, hl;
    int hc;
    int err_count = 0;
    int tests_run = 0;
    initial forever #10 clk = ~clk;
    dtsl_steering_latch #(.GUARD_PRESENT_CYC_P(G), .GUARD_ABSENT_CYC_P(A), .RECOVERY_CYC_P(R)) i_dut (
        .core_clk_in(clk), .rstn_in(rstn), .tone_valid_in(tv), .tone_code_in(code), .power_down_in(pd),
        .code_output_enable_in(oe), .host_ready_in(hr), .early_detect_out(ed), .guard_steer_pin_out(gp),
        .delayed_valid_strobe_out(sd), .tone_code_out(q), .tone_code_oe_out(qoe), .code_valid_out(cv),
        .code_data_out(cd));
    dtsl_host_model i_host (.clk_in(clk), .rstn_in(rstn), .valid_in(cv), .data_in(cd), .stall_in(stall),
        .ready_out(hr), .count_out(hc), .last_out(hl));
    task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task close_out;
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    initial begin
        cyc(6);
        chk("early", {7'h0, ed}, 8'h00);
        chk("strobe", {7'h0, sd}, 8'h00);
        chk("code", {4'h0, q}, 8'h00);
        rstn = 1;
        cyc(R + 5);
        stall = 1;
        foreach (rows[k]) begin
            oe = rows[k].oe;
            code = rows[k].c;
            tv = 1;
            saw = 0;
            for (int i = 0; i < rows[k].len; i++) begin
                cyc(1);
                if (i == 2) chk("early", {7'h0, ed}, 8'h01);
                if (sd && !saw) chk("lead", {4'h0, q}, {4'h0, rows[k].q});
                saw = saw | sd;
            end
            tv = 0;
            cyc(A + 5);
            chk("seen", {7'h0, saw}, {7'h0, rows[k].st});
            chk("held", {4'h0, q}, {4'h0, rows[k].q});
            chk("oe", {4'h0, qoe}, {4'h0, {4{oe}}});
            chk("end", {7'h0, sd}, 8'h00);
        end
        code = 4'h7;
        tv = 1;
        cyc(G + 200);
        chk("steer", {7'h0, gp}, 8'h01);
        tv = 0;
        cyc(A / 2);
        chk("dropout", {7'h0, sd}, 8'h01);
        tv = 1;
        cyc(A);
        chk("dropout", {7'h0, sd}, 8'h01);
        chk("code", {4'h0, q}, 8'h07);
        tv = 0;
        cyc(A + 5);
        chk("steer", {7'h0, gp}, 8'h00);
        // buffer held two words, third was dropped
        stall = 0;
        cyc(4);
        chk("words", hc[7:0], 8'h02);
        chk("last", {4'h0, hl}, 8'h0A);
        chk("empty", {7'h0, cv}, 8'h00);
        pd = 1;
        tv = 1;
        cyc(5);
        pd = 0;
        cyc(R - 3);
        chk("recover", {7'h0, ed}, 8'h00);
        cyc(8);
        chk("recover", {7'h0, ed}, 8'h01);
        tv = 0;
        close_out;
    end
    initial begin
        #(20 * 10000);
        err_count++;
        close_out;
    end
endmodule
`default_nettype wire
